/* irsc_pkg.sv */
// constants for the repeated start / stop collision block
// Contract
// - a repeated start flags a collision if sda is low when scl rises.
// - a repeated start flags a collision if scl falls during the count before the device pulls sda low.
// - a repeated start loads the baud counter from reload bits 6:0 with sda released, counts to zero, then releases scl.
// - once scl is seen high in a repeated start, sda is sampled and if high the counter reloads for a new count.
// - sda falling during that reloaded count is not a collision.
// - if scl and sda are both high at expiry, sda is driven low and the counter reloads again.
// - at the end of the final count scl is driven low whatever its level and the repeated start completes.
// - a stop starts with sda held low and releases scl once sda is sampled low.
// - in a stop, after scl is seen high (stretching honoured), the counter loads from reload bits 6:0 and counts to zero.
// - in a stop, after expiry and sda release, sda low at the sample is a collision.
// - in a stop, scl low after its release and before sda goes high is a collision.
// - any collision sets the collision flag and returns the port logic to idle.
// - a collision aborts the sequence, releases both lines and clears the matching enable bit.
package irsc_pkg;
    // register byte offsets
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_RELOAD = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    // control field positions
    localparam int CTL_RESTART_BIT = 0;
    localparam int CTL_STOP_BIT = 1;
    // status field positions
    localparam int STA_COLLISION_BIT = 0;
    localparam int STA_EVENT_BIT = 1;
    localparam int STA_BUSY_BIT = 2;
    // reset values
    localparam logic [6:0] RELOAD_RESET = 7'h00;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
    localparam int RELOAD_MSB = 6;
    // link state machine, gray in declaration order; the stop entry and the returns to idle from ST_RS_REL, ST_RS_DRIVE and ST_SP_CHECK change more than one bit
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_RS_LOW = 4'h1,
        ST_RS_REL = 4'h3,
        ST_RS_HIGH = 4'h2,
        ST_RS_DRIVE = 4'h6,
        ST_SP_LOW = 4'h7,
        ST_SP_REL = 4'h5,
        ST_SP_COUNT = 4'h4,
        ST_SP_CHECK = 4'hc
    } irsc_state_t;
endpackage : irsc_pkg

/* irsc_top.sv */
// repeated start / stop sequencer with bus collision detection
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
module irsc_top (
    input wire logic clock,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe
);
    // ---------------- system clock domain ----------------
    logic waitreq_ff;
    logic [31:0] rdata_ff;
    logic [6:0] baud_reload_field_ff;
    logic restart_sequence_enable_ff;
    logic stop_sequence_enable_ff;
    logic collision_irq_flag_ff;
    logic port_event_flag_ff;
    logic busy_ff;
    logic cmd_tgl_ff;
    logic cmd_is_stop_ff;
    logic [6:0] cmd_reload_ff;
    logic [2:0] done_sync_ff;
    logic [2:0] coll_sync_ff;
    logic done_evt;
    logic coll_evt;
    logic acc_write;
    logic start_rs;
    logic start_sp;
    logic [31:0] nxt_rdata;

    // bus write takes effect on the edge where waitrequest is seen low
    assign acc_write = avs_write && !waitreq_ff;
    assign start_rs = acc_write && avs_address == irsc_pkg::OFS_CONTROL && !busy_ff
        && avs_writedata[irsc_pkg::CTL_RESTART_BIT];
    assign start_sp = acc_write && avs_address == irsc_pkg::OFS_CONTROL && !busy_ff
        && !avs_writedata[irsc_pkg::CTL_RESTART_BIT] && avs_writedata[irsc_pkg::CTL_STOP_BIT];
    // events from the link side, edge taken between second and third stage
    assign done_evt = done_sync_ff[1] ^ done_sync_ff[2];
    assign coll_evt = coll_sync_ff[1] ^ coll_sync_ff[2];

    // read mux, unmapped offsets read zero
    always_comb begin
        nxt_rdata = irsc_pkg::RDATA_RESET;
        case (avs_address)
            irsc_pkg::OFS_CONTROL: begin
                nxt_rdata[irsc_pkg::CTL_RESTART_BIT] = restart_sequence_enable_ff;
                nxt_rdata[irsc_pkg::CTL_STOP_BIT] = stop_sequence_enable_ff;
            end
            irsc_pkg::OFS_RELOAD: begin
                nxt_rdata[irsc_pkg::RELOAD_MSB:0] = baud_reload_field_ff;
            end
            irsc_pkg::OFS_STATUS: begin
                nxt_rdata[irsc_pkg::STA_COLLISION_BIT] = collision_irq_flag_ff;
                nxt_rdata[irsc_pkg::STA_EVENT_BIT] = port_event_flag_ff;
                nxt_rdata[irsc_pkg::STA_BUSY_BIT] = busy_ff;
            end
            default: begin
                nxt_rdata = irsc_pkg::RDATA_RESET;
            end
        endcase
    end

    // one wait cycle, then the answer; drops back high after each accept
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            waitreq_ff <= 1'b1;
            rdata_ff <= irsc_pkg::RDATA_RESET;
        end else if ((avs_read || avs_write) && waitreq_ff) begin
            waitreq_ff <= 1'b0;
            rdata_ff <= nxt_rdata;
        end else begin
            waitreq_ff <= 1'b1;
        end
    end

    // reload field; only copied to the link side at command time
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            baud_reload_field_ff <= irsc_pkg::RELOAD_RESET;
        end else if (acc_write && avs_address == irsc_pkg::OFS_RELOAD) begin
            baud_reload_field_ff <= avs_writedata[irsc_pkg::RELOAD_MSB:0];
        end
    end

    // command launch; reload copy is stable while the toggle crosses
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cmd_tgl_ff <= 1'b0;
            cmd_is_stop_ff <= 1'b0;
            cmd_reload_ff <= irsc_pkg::RELOAD_RESET;
        end else if (start_rs || start_sp) begin
            cmd_tgl_ff <= !cmd_tgl_ff;
            cmd_is_stop_ff <= start_sp;
            cmd_reload_ff <= baud_reload_field_ff;
        end
    end

    // enables self-clear on completion or collision
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            restart_sequence_enable_ff <= 1'b0;
            stop_sequence_enable_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else if (start_rs || start_sp) begin
            restart_sequence_enable_ff <= start_rs;
            stop_sequence_enable_ff <= start_sp;
            busy_ff <= 1'b1;
        end else if (done_evt || coll_evt) begin
            restart_sequence_enable_ff <= 1'b0;
            stop_sequence_enable_ff <= 1'b0;
            busy_ff <= 1'b0;
        end
    end

    // sticky flags, write one to clear; a new event beats the clear
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            collision_irq_flag_ff <= 1'b0;
            port_event_flag_ff <= 1'b0;
        end else begin
            if (coll_evt) begin
                collision_irq_flag_ff <= 1'b1;
            end else if (acc_write && avs_address == irsc_pkg::OFS_STATUS
                && avs_writedata[irsc_pkg::STA_COLLISION_BIT]) begin
                collision_irq_flag_ff <= 1'b0;
            end
            if (done_evt) begin
                port_event_flag_ff <= 1'b1;
            end else if (acc_write && avs_address == irsc_pkg::OFS_STATUS
                && avs_writedata[irsc_pkg::STA_EVENT_BIT]) begin
                port_event_flag_ff <= 1'b0;
            end
        end
    end

    // ---------------- link clock domain ----------------
    logic [2:0] sda_sync_ff;
    logic [2:0] scl_sync_ff;
    logic sda_q_ff;
    logic scl_q_ff;
    logic [2:0] cmd_sync_ff;
    logic cmd_new;
    irsc_pkg::irsc_state_t state_ff;
    logic [6:0] baud_down_counter_ff;
    logic expired;
    logic sda_oe_ff;
    logic scl_oe_ff;
    logic done_tgl_ff;
    logic coll_tgl_ff;
    logic coll_now;
    logic done_now;

    // pins pass three stages; a level counts once stages two and three agree
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            sda_sync_ff <= 3'h7;
            scl_sync_ff <= 3'h7;
            sda_q_ff <= 1'b1;
            scl_q_ff <= 1'b1;
        end else begin
            sda_sync_ff <= {sda_sync_ff[1:0], sda_i};
            scl_sync_ff <= {scl_sync_ff[1:0], scl_i};
            if (sda_sync_ff[1] == sda_sync_ff[2]) begin
                sda_q_ff <= sda_sync_ff[2];
            end
            if (scl_sync_ff[1] == scl_sync_ff[2]) begin
                scl_q_ff <= scl_sync_ff[2];
            end
        end
    end

    // command toggle from the system side
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            cmd_sync_ff <= 3'h0;
        end else begin
            cmd_sync_ff <= {cmd_sync_ff[1:0], cmd_tgl_ff};
        end
    end
    assign cmd_new = cmd_sync_ff[1] ^ cmd_sync_ff[2];
    assign expired = baud_down_counter_ff == 7'h00;

    // collision conditions per state
    always_comb begin
        coll_now = 1'b0;
        done_now = 1'b0;
        case (state_ff)
            irsc_pkg::ST_RS_REL: begin
                coll_now = scl_q_ff && !sda_q_ff;
            end
            irsc_pkg::ST_RS_HIGH: begin
                coll_now = !scl_q_ff;
            end
            irsc_pkg::ST_RS_DRIVE: begin
                done_now = expired;
            end
            irsc_pkg::ST_SP_COUNT: begin
                coll_now = !scl_q_ff;
            end
            irsc_pkg::ST_SP_CHECK: begin
                coll_now = expired ? !sda_q_ff : (!scl_q_ff && !sda_q_ff);
                done_now = expired && sda_q_ff;
            end
            default: begin
                coll_now = 1'b0;
            end
        endcase
    end

    // sequencer: lines, baud counter and state together
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            state_ff <= irsc_pkg::ST_IDLE;
            baud_down_counter_ff <= irsc_pkg::RELOAD_RESET;
            sda_oe_ff <= 1'b0;
            scl_oe_ff <= 1'b0;
        end else if (coll_now) begin
            state_ff <= irsc_pkg::ST_IDLE;
            sda_oe_ff <= 1'b0;
            scl_oe_ff <= 1'b0;
        end else begin
            if (!expired) begin
                baud_down_counter_ff <= baud_down_counter_ff - 7'h01;
            end
            case (state_ff)
                irsc_pkg::ST_IDLE: begin
                    if (cmd_new && !cmd_is_stop_ff) begin
                        sda_oe_ff <= 1'b0;
                        scl_oe_ff <= 1'b1;
                        baud_down_counter_ff <= cmd_reload_ff;
                        state_ff <= irsc_pkg::ST_RS_LOW;
                    end else if (cmd_new) begin
                        sda_oe_ff <= 1'b1;
                        scl_oe_ff <= 1'b1;
                        state_ff <= irsc_pkg::ST_SP_LOW;
                    end
                end
                irsc_pkg::ST_RS_LOW: begin
                    if (expired) begin
                        scl_oe_ff <= 1'b0;
                        state_ff <= irsc_pkg::ST_RS_REL;
                    end
                end
                irsc_pkg::ST_RS_REL: begin
                    if (scl_q_ff) begin
                        baud_down_counter_ff <= cmd_reload_ff;
                        state_ff <= irsc_pkg::ST_RS_HIGH;
                    end
                end
                irsc_pkg::ST_RS_HIGH: begin
                    // an early sda fall from elsewhere is harmless here
                    if (expired) begin
                        sda_oe_ff <= 1'b1;
                        baud_down_counter_ff <= cmd_reload_ff;
                        state_ff <= irsc_pkg::ST_RS_DRIVE;
                    end
                end
                irsc_pkg::ST_RS_DRIVE: begin
                    if (expired) begin
                        scl_oe_ff <= 1'b1;
                        state_ff <= irsc_pkg::ST_IDLE;
                    end
                end
                irsc_pkg::ST_SP_LOW: begin
                    if (!sda_q_ff) begin
                        scl_oe_ff <= 1'b0;
                        state_ff <= irsc_pkg::ST_SP_REL;
                    end
                end
                irsc_pkg::ST_SP_REL: begin
                    // waits as long as another party stretches scl
                    if (scl_q_ff) begin
                        baud_down_counter_ff <= cmd_reload_ff;
                        state_ff <= irsc_pkg::ST_SP_COUNT;
                    end
                end
                irsc_pkg::ST_SP_COUNT: begin
                    if (expired) begin
                        sda_oe_ff <= 1'b0;
                        baud_down_counter_ff <= cmd_reload_ff;
                        state_ff <= irsc_pkg::ST_SP_CHECK;
                    end
                end
                irsc_pkg::ST_SP_CHECK: begin
                    if (expired) begin
                        state_ff <= irsc_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= irsc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // event toggles back to the system side
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            done_tgl_ff <= 1'b0;
            coll_tgl_ff <= 1'b0;
        end else begin
            if (done_now && !coll_now) begin
                done_tgl_ff <= !done_tgl_ff;
            end
            if (coll_now) begin
                coll_tgl_ff <= !coll_tgl_ff;
            end
        end
    end

    // toggles into the system clock, three stages for the edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            done_sync_ff <= 3'h0;
            coll_sync_ff <= 3'h0;
        end else begin
            done_sync_ff <= {done_sync_ff[1:0], done_tgl_ff};
            coll_sync_ff <= {coll_sync_ff[1:0], coll_tgl_ff};
        end
    end

    // open-drain: data is always low, enable pulls the line
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            sda_o <= 1'b0;
            scl_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
            scl_o <= 1'b0;
        end
    end

    assign sda_oe = sda_oe_ff;
    assign scl_oe = scl_oe_ff;
    assign avs_readdata = rdata_ff;
    assign avs_waitrequest = waitreq_ff;

    // ---------------- checks ----------------
    property p_rs_low_coll;
        @(posedge link_clk) disable iff (rst)
        state_ff == irsc_pkg::ST_RS_REL && scl_q_ff && !sda_q_ff |=> state_ff == irsc_pkg::ST_IDLE;
    endproperty
    a_rs_low_coll: assert property (p_rs_low_coll) else $error("no abort on low sda at scl rise");

    property p_rs_scl_fall;
        @(posedge link_clk) disable iff (rst)
        state_ff == irsc_pkg::ST_RS_HIGH && !scl_q_ff |=> !scl_oe_ff && !sda_oe_ff && $changed(coll_tgl_ff);
    endproperty
    a_rs_scl_fall: assert property (p_rs_scl_fall) else $error("scl fall in restart not flagged");

    property p_rs_release;
        @(posedge link_clk) disable iff (rst)
        state_ff == irsc_pkg::ST_RS_LOW && expired |=> !scl_oe_ff && !sda_oe_ff;
    endproperty
    a_rs_release: assert property (p_rs_release) else $error("scl not released after count");

    property p_rs_reload;
        @(posedge link_clk) disable iff (rst)
        state_ff == irsc_pkg::ST_RS_REL && scl_q_ff && sda_q_ff
        |=> baud_down_counter_ff == cmd_reload_ff && state_ff == irsc_pkg::ST_RS_HIGH;
    endproperty
    a_rs_reload: assert property (p_rs_reload) else $error("counter not reloaded on sda high");

    property p_rs_drive;
        @(posedge link_clk) disable iff (rst)
        state_ff == irsc_pkg::ST_RS_HIGH && expired && scl_q_ff |=> sda_oe_ff && scl_oe_ff == 1'b0;
    endproperty
    a_rs_drive: assert property (p_rs_drive) else $error("sda not driven at restart expiry");

    property p_rs_done;
        @(posedge link_clk) disable iff (rst)
        state_ff == irsc_pkg::ST_RS_DRIVE && expired |=> scl_oe_ff && state_ff == irsc_pkg::ST_IDLE;
    endproperty
    a_rs_done: assert property (p_rs_done) else $error("scl not driven low at restart end");

    property p_sp_release;
        @(posedge link_clk) disable iff (rst)
        state_ff == irsc_pkg::ST_SP_LOW && !sda_q_ff |=> sda_oe_ff && !scl_oe_ff;
    endproperty
    a_sp_release: assert property (p_sp_release) else $error("scl not released in stop");

    property p_sp_sda_low;
        @(posedge link_clk) disable iff (rst)
        state_ff == irsc_pkg::ST_SP_CHECK && expired && !sda_q_ff |=> $changed(coll_tgl_ff) && !sda_oe_ff;
    endproperty
    a_sp_sda_low: assert property (p_sp_sda_low) else $error("low sda after stop not flagged");

    property p_sp_scl_low;
        @(posedge link_clk) disable iff (rst)
        state_ff == irsc_pkg::ST_SP_COUNT && !scl_q_ff |=> state_ff == irsc_pkg::ST_IDLE ##1 !sda_oe_ff;
    endproperty
    a_sp_scl_low: assert property (p_sp_scl_low) else $error("scl low in stop not flagged");

    property p_flag_set;
        @(posedge clock) disable iff (rst)
        coll_evt |=> collision_irq_flag_ff && !restart_sequence_enable_ff && !stop_sequence_enable_ff;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("collision flag or enables wrong");
endmodule : irsc_top

/* irsc_bus_model.sv */
// far-side bus model: pull-ups plus another master that can pull, stretch or fight
module irsc_bus_model (
    input wire logic link_clk,
    input wire logic rst,
    input wire logic dut_sda_oe,
    input wire logic dut_scl_oe,
    input wire logic [2:0] mode,
    output logic sda,
    output logic scl
);
    timeunit 1ns;
    timeprecision 100ps;
    logic oth_sda_ff;
    logic oth_scl_ff;
    logic prev_oe_ff;
    logic done_ff;
    logic [5:0] hi_ff;
    logic [5:0] hold_ff;
    // open-drain wires: released lines go high through the pull-ups
    assign sda = !(dut_sda_oe | oth_sda_ff | (mode == 3'h1));
    assign scl = !(dut_scl_oe | oth_scl_ff);
    // high time of a released scl, the cue for the other master to act
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            hi_ff <= 6'h00;
            prev_oe_ff <= 1'b0;
        end else begin
            prev_oe_ff <= dut_scl_oe;
            hi_ff <= (scl && !dut_scl_oe && hi_ff != 6'h3f) ? hi_ff + 6'h01 : (scl ? hi_ff : 6'h00);
        end
    end
    // one action per run; done holds until the bench returns to mode 0
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            oth_sda_ff <= 1'b0;
            oth_scl_ff <= 1'b0;
            done_ff <= 1'b0;
            hold_ff <= 6'h00;
        end else if (mode == 3'h0) begin
            // idle between runs: let go of both lines and rearm
            oth_sda_ff <= 1'b0;
            oth_scl_ff <= 1'b0;
            done_ff <= 1'b0;
            hold_ff <= 6'h00;
        end else if (hold_ff != 6'h00) begin
            hold_ff <= hold_ff - 6'h01;
            oth_scl_ff <= hold_ff != 6'h01;
        end else if (oth_sda_ff) begin
            oth_sda_ff <= !dut_sda_oe; // let go once the device drives sda itself
        end else if (!done_ff && mode == 3'h2 && hi_ff == 6'h06) begin
            oth_scl_ff <= 1'b1;
            hold_ff <= 6'h14;
            done_ff <= 1'b1;
        end else if (!done_ff && mode == 3'h3 && prev_oe_ff && !dut_scl_oe) begin
            oth_scl_ff <= 1'b1; // stretch the clock after the device releases it
            hold_ff <= 6'h0a;
            done_ff <= 1'b1;
        end else if (!done_ff && mode == 3'h4 && hi_ff == 6'h06 && !dut_sda_oe) begin
            oth_sda_ff <= 1'b1; // another master starts first, not a collision
            done_ff <= 1'b1;
        end
    end
endmodule : irsc_bus_model

/* test_irsc_top.sv */
// self-checking bench for the repeated start / stop collision block
module test_irsc_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic sda_i;
    logic sda_o;
    logic sda_oe;
    logic scl_i;
    logic scl_o;
    logic scl_oe;
    logic [2:0] mode = 3'h0;
    logic [31:0] lfsr = 32'h0001_328e;
    logic [31:0] rd;
    int miscompares = 0;
    int comparisons = 0;
    // two unrelated clocks, the link one offset so edges never line up
    initial begin
        forever #50 clock = !clock;
    end
    initial begin
        #1.7;
        forever #3 link_clk = !link_clk;
    end
    irsc_top i_dut (
        .clock(clock), .rst(rst), .link_clk(link_clk),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe)
    );
    irsc_bus_model i_bus (
        .link_clk(link_clk), .rst(rst), .dut_sda_oe(sda_oe), .dut_scl_oe(scl_oe),
        .mode(mode), .sda(sda_i), .scl(scl_i)
    );
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr_next
    // expected status after a sequence: exactly one of the two flags
    function automatic logic [31:0] exp_status(input logic coll);
        logic [31:0] e;
        e = 32'h0000_0000;
        e[irsc_pkg::STA_COLLISION_BIT] = coll;
        e[irsc_pkg::STA_EVENT_BIT] = !coll;
        return e;
    endfunction : exp_status
    task automatic complete_run;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // one avalon access; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 50) begin
            miscompares++;
            complete_run();
        end
    endtask : bus
    // start one sequence with the far side in a given mood, then judge the outcome
    task automatic run(input logic [31:0] cmd, input logic [2:0] m, input logic coll);
        int n;
        logic [31:0] q;
        mode <= m;
        bus(1'b1, irsc_pkg::OFS_CONTROL, cmd, q);
        // read back at once: even the quickest collision clears the enable later than this
        bus(1'b0, irsc_pkg::OFS_CONTROL, 32'h0, q);
        check("enable while busy", q, cmd[irsc_pkg::CTL_RESTART_BIT] ? 32'h0000_0001 : 32'h0000_0002);
        repeat (4) @(posedge clock);
        n = 0;
        do begin
            bus(1'b0, irsc_pkg::OFS_STATUS, 32'h0, q);
            n++;
        end while (q[irsc_pkg::STA_BUSY_BIT] !== 1'b0 && n < 200);
        if (n >= 200) begin
            miscompares++;
            complete_run();
        end
        repeat (4) @(posedge clock);
        bus(1'b0, irsc_pkg::OFS_STATUS, 32'h0, q);
        check("status", q, exp_status(coll));
        bus(1'b0, irsc_pkg::OFS_CONTROL, 32'h0, q);
        check("control", q, 32'h0000_0000);
        if (coll) begin
            check("oe after collision", {30'h0, sda_oe, scl_oe}, 32'h0000_0000);
        end else if (cmd[irsc_pkg::CTL_RESTART_BIT]) begin
            check("oe after restart", {30'h0, sda_oe, scl_oe}, 32'h0000_0003);
        end else begin
            check("oe after stop", {30'h0, sda_oe, scl_oe}, 32'h0000_0000);
        end
        bus(1'b1, irsc_pkg::OFS_STATUS, 32'h0000_0003, q);
        bus(1'b0, irsc_pkg::OFS_STATUS, 32'h0, q);
        check("status cleared", q, 32'h0000_0000);
        mode <= 3'h0;
        @(posedge clock);
    endtask : run
    // command, far-side mode, collision expected
    // entry 4 sets both enables: restart must win
    logic [31:0] cmds [9] = '{32'h1, 32'h2, 32'h1, 32'h1, 32'h3, 32'h2, 32'h2, 32'h1, 32'h2};
    logic [2:0] modes [9] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h4, 3'h1, 3'h2, 3'h3, 3'h3};
    logic colls [9] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        check("oe at reset", {30'h0, sda_oe, scl_oe}, 32'h0000_0000);
        check("o at reset", {30'h0, sda_o, scl_o}, 32'h0000_0000);
        bus(1'b0, irsc_pkg::OFS_RELOAD, 32'h0, rd);
        check("reload reset", rd, {25'h0, irsc_pkg::RELOAD_RESET});
        bus(1'b0, irsc_pkg::OFS_STATUS, 32'h0, rd);
        check("status reset", rd, 32'h0000_0000);
        // unmapped place: write ignored, reads zero
        bus(1'b1, 4'hc, 32'hffff_ffff, rd);
        bus(1'b0, 4'hc, 32'h0, rd);
        check("unmapped", rd, 32'h0000_0000);
        for (int p = 0; p < 3; p++) begin
            // random reload, only bits 6:0 kept; at least 8 so the far side can act mid-count
            lfsr = lfsr_next(lfsr);
            bus(1'b1, irsc_pkg::OFS_RELOAD, lfsr | 32'h0000_0008, rd);
            bus(1'b0, irsc_pkg::OFS_RELOAD, 32'h0, rd);
            check("reload", rd, (lfsr | 32'h0000_0008) & 32'h0000_007f);
            for (int k = 0; k < 9; k++) begin
                run(cmds[k], modes[k], colls[k]);
            end
        end
        complete_run();
    end
endmodule : test_irsc_top
